// ==== hw/port_statistics_counters.sv ====
// per-port statistics counter bank with indirect byte access
//
// Summary of operation
// R1 - port groups at 0x00, 0x20, 0x40, 0x80
// R2 - bit 38 flags counter overflow
// R3 - count in 29:0, 36:30 zero, 37 valid
// R4 - offset 0x0 sums received high-priority octets
// R5 - count good-crc undersize and oversize frames
// R6 - count short frames with any error
// R7 - count long errored or over-1916 frames
// R8 - count legal frames with bad symbol
// R9 - bad crc split by whole-byte length
// R10 - count received control type frames
// R11 - count qualified received pause frames
// R12 - count good received broadcast, multicast, unicast
// R13 - bin received frames from 64 bytes to below MAX_PKT_LEN by length
// R14 - sum good transmitted high-priority octets
// R15 - count late transmit collisions
// R16 - count transmitted pause frames
// R17 - count good transmitted broadcast, multicast, unicast
// R18 - count transmits delayed by busy medium
// R19 - count collisions and collided frame outcomes
// R20 - host reads eee global via 0x30 control
// R21 - host writes eee global via 0x20 control
// R22 - port field zero selects eee global
// R23 - reading a counter clears it
// R24 - host triggers counter read with 0x1c
// R25 - trigger latches counter for coherent reads
`timescale 1ns/1ps
`default_nettype none
`include "port_stats_consts.svh"

module port_statistics_counters
	import port_stats_pkg::*;
#(
	parameter logic [11:0] MAX_PKT_LEN   = 12'h800,
	parameter int          EEE_GLB_BYTES = 2
) (
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic              ce,
	input  wire logic              long_frame_mode,
	input  wire logic [3:0]        rx_evt_valid,
	input  wire rx_evt_t [3:0]     rx_evt,
	input  wire logic [3:0]        tx_evt_valid,
	input  wire tx_evt_t [3:0]     tx_evt,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output var  logic [7:0]        reg_rdata_q
);

	// ======================================================================
	// elaboration checks
	if (MAX_PKT_LEN <= `LEN_BIN7_HI + 12'h001) begin : g_bad_max
		$error("MAX_PKT_LEN must exceed 2001");
	end
	if (EEE_GLB_BYTES < 1 || EEE_GLB_BYTES > 208) begin : g_bad_eee
		$error("EEE_GLB_BYTES out of range");
	end

	// ======================================================================
	// functions
	function automatic logic [2:0] grp_to_port(input logic [2:0] grp);
		logic [2:0] r;
		r = 3'h0;
		case (grp) // see R1
			`GRP_PORT1: r = 3'b100;
			`GRP_PORT2: r = 3'b101;
			`GRP_PORT3: r = 3'b110;
			`GRP_PORT4: r = 3'b111;
			default:    r = 3'b000;
		endcase
		return r;
	endfunction

	function automatic inc_vec_t stats_inc(
		input rx_evt_t rx,
		input logic    rxv,
		input tx_evt_t tx,
		input logic    txv,
		input logic    lfm
	);
		inc_vec_t   v;
		logic [11:0] lim;
		logic [11:0] l;
		logic       err;
		logic       good;
		logic       tgood;
		v     = '0;
		lim   = lfm ? `LEN_LONG_MAX : `LEN_STD_MAX;
		l     = rx.len;
		err   = rx.crc_bad | rx.sym_err | rx.align_err;
		good  = !err && l >= `LEN_MIN && l <= lim;
		tgood = txv & tx.good;
		if (rxv) begin
			v[RX_HIGH_PRIORITY_OCTETS] = rx.high_pri ? l : 12'h000; // see R4
			v[RX_UNDERSIZE_COUNT][0] = l < `LEN_MIN && !rx.crc_bad; // see R5
			v[RX_OVERSIZE_COUNT][0]  = l > lim && !rx.crc_bad; // see R5
			v[RX_FRAGMENT_COUNT][0]  = l < `LEN_MIN && err; // see R6
			v[RX_JABBER_COUNT][0]    = (l > lim && err) || l > `LEN_JABBER; // see R7
			v[RX_BAD_SYMBOL_COUNT][0] = rx.sym_err && rx.preamble_ok &&
				l >= `LEN_MIN && l <= lim; // see R8
			v[RX_BAD_CHECKSUM_COUNT][0] = rx.crc_bad && !rx.align_err &&
				l >= `LEN_MIN && l <= lim; // see R9
			v[RX_MISALIGNED_COUNT][0] = rx.crc_bad && rx.align_err &&
				l >= `LEN_MIN && l <= lim; // see R9
			v[RX_CONTROL_FRAME_COUNT][0] = rx.ctrl_type; // see R10
			v[RX_PAUSE_COUNT][0] = rx.ctrl_type && rx.pause_match &&
				l >= `LEN_MIN && !rx.crc_bad; // see R11
			v[RX_BROADCAST_COUNT][0] = good && rx.bcast; // see R12
			v[RX_MULTICAST_COUNT][0] = good && rx.mcast && !rx.ctrl_type; // see R12
			v[RX_SINGLE_DEST_COUNT][0] = good && rx.ucast; // see R12
			v[RX_LEN_BIN_64][0] = l == `LEN_MIN; // see R13
			v[RX_LEN_BIN_65_127][0] = l > `LEN_MIN && l <= `LEN_BIN2_HI;
			v[RX_LEN_BIN_128_255][0] = l > `LEN_BIN2_HI && l <= `LEN_BIN3_HI;
			v[RX_LEN_BIN_256_511][0] = l > `LEN_BIN3_HI && l <= `LEN_BIN4_HI;
			v[RX_LEN_BIN_512_1023][0] = l > `LEN_BIN4_HI && l <= `LEN_BIN5_HI;
			v[RX_LEN_BIN_1024_1522][0] = l > `LEN_BIN5_HI && l <= `LEN_STD_MAX;
			v[RX_LEN_BIN_1523_2000][0] = l > `LEN_STD_MAX && l <= `LEN_BIN7_HI;
			v[RX_LEN_BIN_2001_MAX][0] = l > `LEN_BIN7_HI && l < MAX_PKT_LEN;
		end
		if (txv) begin
			v[TX_HIGH_PRIORITY_OCTETS] = (tgood && tx.high_pri) ? tx.len : 12'h000; // see R14
			v[TX_LATE_CLASH_COUNT][0] = tx.late_col; // see R15
			v[TX_PAUSE_COUNT][0] = tx.pause; // see R16
			v[TX_BROADCAST_COUNT][0] = tgood && tx.bcast; // see R17
			v[TX_MULTICAST_COUNT][0] = tgood && tx.mcast; // see R17
			v[TX_SINGLE_DEST_COUNT][0] = tgood && tx.ucast; // see R17
			v[TX_DELAYED_START_COUNT][0] = tx.deferred; // see R18
			v[TX_ALL_CLASH_COUNT] = {7'h00, tx.col_cnt}; // see R19
			v[TX_EXCESS_CLASH_COUNT][0] = tx.excess_col; // see R19
			v[TX_ONE_CLASH_COUNT][0] = tgood && tx.col_cnt == 5'h01; // see R19
			v[TX_MANY_CLASH_COUNT][0] = tgood && tx.col_cnt > 5'h01; // see R19
		end
		return v;
	endfunction

	// ======================================================================
	// state
	logic [7:0]            ctl_q;
	logic [7:0]            off_q;
	logic [7:0]            data_byte_q;
	rd_word_t              rd_word_q;
	logic [29:0]           cnt_q [4][32];
	logic                  ovf_q [4][32];
	logic [7:0]            eee_q [EEE_GLB_BYTES];
	inc_vec_t              inc   [4];

	// ======================================================================
	// access decode
	logic       trig;
	logic       mib_read;
	logic       eee_sel;
	logic [2:0] grp_map;
	logic       hit;
	logic [1:0] hit_port;
	logic [4:0] hit_idx;
	logic [7:0] eee_rd_idx;
	logic [7:0] eee_wr_idx;

	assign trig     = ce && reg_wr && reg_addr == `ADDR_OFFSET_TRIG;
	assign mib_read = ctl_q[`CTL_SEL_MSB:`CTL_SEL_LSB] == `CTL_SEL_TABLE &&
		ctl_q[`CTL_READ_BIT] && ctl_q[`CTL_TBL_MSB:`CTL_TBL_LSB] == `CTL_TBL_STATS; // see R24
	// only the global set lives here; per-port eee bytes sit elsewhere
	assign eee_sel  = ctl_q[`CTL_SEL_MSB:`CTL_SEL_LSB] == `CTL_SEL_EEE &&
		ctl_q[`CTL_TBL_MSB:0] == 4'h0; // see R22
	assign grp_map  = grp_to_port(reg_wdata[7:5]);
	assign hit      = trig && mib_read && ctl_q[`CTL_HI_MSB:0] == 2'h0 && grp_map[2]; // see R1
	assign hit_port = grp_map[1:0];
	assign hit_idx  = reg_wdata[4:0];
	assign eee_rd_idx = reg_wdata - `EEE_GLB_BASE;
	assign eee_wr_idx = off_q - `EEE_GLB_BASE;

	always_comb begin
		for (int p = 0; p < 4; p++) begin
			inc[p] = stats_inc(rx_evt[p], rx_evt_valid[p], tx_evt[p],
				tx_evt_valid[p], long_frame_mode);
		end
	end

	// ======================================================================
	// control and offset bytes
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ctl_q <= `RST_BYTE;
			off_q <= `RST_BYTE;
		end else if (ce && reg_wr) begin
			if (reg_addr == `ADDR_ACCESS_CTL) begin
				ctl_q <= reg_wdata;
			end
			if (reg_addr == `ADDR_OFFSET_TRIG) begin
				off_q <= reg_wdata;
			end
		end
	end

	// ======================================================================
	// counters: events landing on a read go into the fresh count
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int p = 0; p < 4; p++) begin
				for (int c = 0; c < 32; c++) begin
					cnt_q[p][c] <= '0;
					ovf_q[p][c] <= 1'b0;
				end
			end
		end else if (ce) begin
			for (int p = 0; p < 4; p++) begin
				for (int c = 0; c < 32; c++) begin
					if (hit && hit_port == p[1:0] && hit_idx == c[4:0]) begin
						cnt_q[p][c] <= {18'h0_0000, inc[p][c]}; // see R23
						ovf_q[p][c] <= 1'b0; // see R23
					end else begin
						{ovf_q[p][c], cnt_q[p][c]} <= {1'b0, cnt_q[p][c]} +
							{19'h0_0000, inc[p][c]} | {ovf_q[p][c], 30'h0000_0000}; // see R2
					end
				end
			end
		end
	end

	// ======================================================================
	// latched read word
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rd_word_q <= `RST_RD_WORD;
		end else if (trig && mib_read) begin
			rd_word_q <= `RST_RD_WORD;
			if (hit) begin
				rd_word_q.ovf   <= ovf_q[hit_port][hit_idx]; // see R2
				rd_word_q.valid <= 1'b1; // see R3
				rd_word_q.count <= cnt_q[hit_port][hit_idx]; // see R25
			end
		end
	end

	// ======================================================================
	// energy efficient ethernet global bytes and the data window
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			data_byte_q <= `RST_BYTE;
			for (int i = 0; i < EEE_GLB_BYTES; i++) begin
				eee_q[i] <= `RST_BYTE;
			end
		end else if (ce) begin
			if (trig && eee_sel && ctl_q[`CTL_READ_BIT]) begin
				data_byte_q <= `RST_BYTE; // see R20
				for (int i = 0; i < EEE_GLB_BYTES; i++) begin
					if (eee_rd_idx == i[7:0]) begin
						data_byte_q <= eee_q[i]; // see R20
					end
				end
			end
			if (reg_wr && reg_addr == `ADDR_DATA_BYTE) begin
				data_byte_q <= reg_wdata;
				for (int i = 0; i < EEE_GLB_BYTES; i++) begin
					if (eee_sel && !ctl_q[`CTL_READ_BIT] && eee_wr_idx == i[7:0]) begin
						eee_q[i] <= reg_wdata; // see R21
					end
				end
			end
		end
	end

	// ======================================================================
	// register read port, highest byte first
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			reg_rdata_q <= `RST_BYTE;
		end else if (ce && reg_rd) begin
			case (reg_addr)
				`ADDR_ACCESS_CTL:  reg_rdata_q <= ctl_q;
				`ADDR_OFFSET_TRIG: reg_rdata_q <= off_q;
				`ADDR_READ_39_32:  reg_rdata_q <= rd_word_q[39:32]; // see R24
				`ADDR_READ_31_24:  reg_rdata_q <= rd_word_q[31:24];
				`ADDR_READ_23_16:  reg_rdata_q <= rd_word_q[23:16];
				`ADDR_READ_15_8:   reg_rdata_q <= rd_word_q[15:8];
				`ADDR_READ_7_0:    reg_rdata_q <= rd_word_q[7:0];
				`ADDR_DATA_BYTE:   reg_rdata_q <= data_byte_q;
				default:           reg_rdata_q <= `RST_BYTE;
			endcase
		end
	end

	// ======================================================================
	// checks
	logic [29:0] sel_cnt;
	logic        sel_ovf;
	logic [11:0] sel_inc;
	logic [1:0]  lat_port_q;
	logic [4:0]  lat_idx_q;
	logic        rx64_p0;
	logic [7:0]  eee_byte0;

	assign sel_cnt   = cnt_q[hit_port][hit_idx];
	assign sel_ovf   = ovf_q[hit_port][hit_idx];
	assign sel_inc   = inc[hit_port][hit_idx];
	assign eee_byte0 = eee_q[0];
	assign rx64_p0   = ce && rx_evt_valid[0] && rx_evt[0].len == `LEN_MIN &&
		!(hit && hit_port == 2'h0 && hit_idx == RX_LEN_BIN_64) &&
		cnt_q[0][RX_LEN_BIN_64] != 30'h3FFF_FFFF;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			lat_port_q <= 2'h0;
			lat_idx_q  <= 5'h00;
		end else if (hit) begin
			lat_port_q <= hit_port;
			lat_idx_q  <= hit_idx;
		end
	end

	sequence s_counter_trigger;
		hit;
	endsequence

	sequence s_word_latched;
		rd_word_q.valid && rd_word_q.rsvd == 7'h00;
	endsequence

	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R3
		rd_word_q.rsvd == 7'h00 && !rd_word_q.zero)
		else $error("reserved read bits not zero");

	a_valid_after_trig: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R3
		s_counter_trigger |=> s_word_latched)
		else $error("valid bit not set after counter trigger");

	a_count_latched: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R25
		hit |=> rd_word_q.count == $past(sel_cnt))
		else $error("latched count differs from counter");

	a_read_clears: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R23
		hit |=> cnt_q[lat_port_q][lat_idx_q] == {18'h0_0000, $past(sel_inc)})
		else $error("counter not cleared by read");

	a_overflow_flag: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R2
		hit |=> rd_word_q.ovf == $past(sel_ovf))
		else $error("overflow bit not reported");

	a_reserved_group: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R1
		trig && mib_read && reg_wdata[7:5] == `GRP_RESERVED |=> rd_word_q == `RST_RD_WORD)
		else $error("reserved group read not zero");

	a_high_byte_read: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R24
		ce && reg_rd && reg_addr == `ADDR_READ_39_32 |=> reg_rdata_q == $past(rd_word_q[39:32]))
		else $error("high read byte wrong");

	a_eee_glb_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R21
		ce && reg_wr && reg_addr == `ADDR_DATA_BYTE && eee_sel && !ctl_q[`CTL_READ_BIT] &&
		off_q == `EEE_GLB_BASE |=> eee_byte0 == $past(reg_wdata))
		else $error("eee global byte not written");

	a_eee_glb_read: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R20
		trig && eee_sel && ctl_q[`CTL_READ_BIT] && reg_wdata == `EEE_GLB_BASE
		|=> data_byte_q == $past(eee_byte0))
		else $error("eee global byte not returned");

	a_bin64_count: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R13
		rx64_p0 |=> cnt_q[0][RX_LEN_BIN_64] == $past(cnt_q[0][RX_LEN_BIN_64]) + 30'h0000_0001)
		else $error("64 byte bin not counted");

	a_ce_freeze: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R13
		!ce |=> $stable(reg_rdata_q) && $stable(ctl_q) && $stable(cnt_q[0][RX_LEN_BIN_64]))
		else $error("state moved while clock enable low");

	a_reset_clears: assert property (@(posedge ref_clk) // see R3
		!reset_n |=> reg_rdata_q == `RST_BYTE && !rd_word_q.valid)
		else $error("read path not cleared by reset");

endmodule // port_statistics_counters
`default_nettype wire

// ==== hw/port_stats_consts.svh ====
// address map, field positions and length limits of the port statistics block
`ifndef PORT_STATS_CONSTS_SVH
`define PORT_STATS_CONSTS_SVH

// ==========================================================================
// byte registers on the switch register port
`define ADDR_ACCESS_CTL   8'h6E
`define ADDR_OFFSET_TRIG  8'h6F
`define ADDR_READ_39_32   8'h74
`define ADDR_READ_31_24   8'h75
`define ADDR_READ_23_16   8'h76
`define ADDR_READ_15_8    8'h77
`define ADDR_READ_7_0     8'h78
`define ADDR_DATA_BYTE    8'hA0
`define RST_BYTE          8'h00

// ==========================================================================
// access control byte fields
`define CTL_SEL_MSB       7
`define CTL_SEL_LSB       5
`define CTL_READ_BIT      4
`define CTL_TBL_MSB       3
`define CTL_TBL_LSB       2
`define CTL_HI_MSB        1
`define CTL_SEL_TABLE     3'h0
`define CTL_SEL_EEE       3'h1
`define CTL_TBL_STATS     2'h3

// ==========================================================================
// per-port groups in the counter space (group = address bits 7:5)
`define GRP_PORT1         3'h0
`define GRP_PORT2         3'h1
`define GRP_PORT3         3'h2
`define GRP_RESERVED      3'h3
`define GRP_PORT4         3'h4

// ==========================================================================
// read word layout
`define RW_OVF_BIT        38
`define RW_VALID_BIT      37
`define RW_CNT_W          30
`define RST_RD_WORD       40'h00_0000_0000

// ==========================================================================
// energy efficient ethernet global bytes
`define EEE_GLB_BASE      8'h30

// ==========================================================================
// frame length limits in bytes
`define LEN_MIN           12'h040
`define LEN_BIN2_HI       12'h07F
`define LEN_BIN3_HI       12'h0FF
`define LEN_BIN4_HI       12'h1FF
`define LEN_BIN5_HI       12'h3FF
`define LEN_STD_MAX       12'h5F2
`define LEN_LONG_MAX      12'h600
`define LEN_JABBER        12'h77C
`define LEN_BIN7_HI       12'h7D0

`endif

// ==== hw/port_stats_pkg.sv ====
// types shared by the port statistics block
package port_stats_pkg;

	// ======================================================================
	// one received frame, as reported by the port mac at end of frame
	typedef struct packed {
		logic [11:0] len;
		logic        crc_bad;
		logic        sym_err;
		logic        align_err;
		logic        high_pri;
		logic        bcast;
		logic        mcast;
		logic        ucast;
		logic        ctrl_type;
		logic        pause_match;
		logic        preamble_ok;
	} rx_evt_t;

	// ======================================================================
	// one transmitted frame, reported when its last attempt ends
	typedef struct packed {
		logic [11:0] len;
		logic        good;
		logic        high_pri;
		logic        pause;
		logic        bcast;
		logic        mcast;
		logic        ucast;
		logic        deferred;
		logic        late_col;
		logic        excess_col;
		logic [4:0]  col_cnt;
	} tx_evt_t;

	// ======================================================================
	// counter index within a port group
	typedef enum logic [4:0] {
		RX_HIGH_PRIORITY_OCTETS = 5'h00, RX_UNDERSIZE_COUNT   = 5'h01,
		RX_FRAGMENT_COUNT       = 5'h02, RX_OVERSIZE_COUNT    = 5'h03,
		RX_JABBER_COUNT         = 5'h04, RX_BAD_SYMBOL_COUNT  = 5'h05,
		RX_BAD_CHECKSUM_COUNT   = 5'h06, RX_MISALIGNED_COUNT  = 5'h07,
		RX_CONTROL_FRAME_COUNT  = 5'h08, RX_PAUSE_COUNT       = 5'h09,
		RX_BROADCAST_COUNT      = 5'h0A, RX_MULTICAST_COUNT   = 5'h0B,
		RX_SINGLE_DEST_COUNT    = 5'h0C, RX_LEN_BIN_64        = 5'h0D,
		RX_LEN_BIN_65_127       = 5'h0E, RX_LEN_BIN_128_255   = 5'h0F,
		RX_LEN_BIN_256_511      = 5'h10, RX_LEN_BIN_512_1023  = 5'h11,
		RX_LEN_BIN_1024_1522    = 5'h12, RX_LEN_BIN_1523_2000 = 5'h13,
		RX_LEN_BIN_2001_MAX     = 5'h14, TX_HIGH_PRIORITY_OCTETS = 5'h15,
		TX_LATE_CLASH_COUNT     = 5'h16, TX_PAUSE_COUNT       = 5'h17,
		TX_BROADCAST_COUNT      = 5'h18, TX_MULTICAST_COUNT   = 5'h19,
		TX_SINGLE_DEST_COUNT    = 5'h1A, TX_DELAYED_START_COUNT = 5'h1B,
		TX_ALL_CLASH_COUNT      = 5'h1C, TX_EXCESS_CLASH_COUNT = 5'h1D,
		TX_ONE_CLASH_COUNT      = 5'h1E, TX_MANY_CLASH_COUNT  = 5'h1F
	} mib_idx_t;

	// per-counter increment amounts of one port in one cycle
	typedef logic [31:0][11:0] inc_vec_t;

	// latched counter read word, bit 39 first
	typedef struct packed {
		logic        zero;
		logic        ovf;
		logic        valid;
		logic [6:0]  rsvd;
		logic [29:0] count;
	} rd_word_t;

endpackage

// ==== testbench/port_statistics_counters_bench.sv ====
// self-checking bench for the port statistics counter bank
`timescale 1ns/1ps
`default_nettype none
`include "port_stats_consts.svh"

module port_statistics_counters_bench
	import port_stats_pkg::*;
;
	localparam logic [9:0] CRC_BAD = 10'h200, SYM_BAD = 10'h100, ALIGN_BAD = 10'h080;
	localparam logic [9:0] PRI_RX = 10'h040, BCAST_RX = 10'h020, MCAST_RX = 10'h010;
	localparam logic [9:0] UCAST_RX = 10'h008, CTRL_RX = 10'h004, PAUSE_RX = 10'h002;
	localparam logic [9:0] PRE_OK = 10'h001;
	localparam logic [8:0] GOOD_TX = 9'h100, PRI_TX = 9'h080, PAUSE_TX = 9'h040;
	localparam logic [8:0] BCAST_TX = 9'h020, MCAST_TX = 9'h010, UCAST_TX = 9'h008;
	localparam logic [8:0] DEFER_TX = 9'h004, LATE_TX = 9'h002, EXCESS_TX = 9'h001;

	logic          ref_clk, reset_n, ce, long_frame_mode, reg_wr, reg_rd;
	logic [3:0]    rx_evt_valid, tx_evt_valid;
	rx_evt_t [3:0] rx_evt;
	tx_evt_t [3:0] tx_evt;
	logic [7:0]    reg_addr, reg_wdata, reg_rdata_q;
	int            fails, samples_checked;

	port_statistics_counters DUT (
		.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .long_frame_mode(long_frame_mode),
		.rx_evt_valid(rx_evt_valid), .rx_evt(rx_evt), .tx_evt_valid(tx_evt_valid),
		.tx_evt(tx_evt), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q)
	);

	always #12.5 ref_clk = ~ref_clk;

	// ======================================================================
	// shared helpers
	task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [39:0] word(input int unsigned n);
		return {3'b001, 7'h00, n[29:0]};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata_q;
	endtask

	task automatic trig(input logic [7:0] a);
		wr(`ADDR_ACCESS_CTL, 8'h1C);
		wr(`ADDR_OFFSET_TRIG, a);
	endtask

	// highest byte first, as software walks it
	task automatic fetch(output logic [39:0] w);
		logic [7:0] b;
		w = '0;
		for (int i = 0; i < 5; i++) begin
			rd(`ADDR_READ_39_32 + 8'(i), b);
			w = {w[31:0], b};
		end
	endtask

	task automatic check_ctr(input string name, input logic [7:0] a, input int n);
		logic [39:0] w;
		trig(a);
		fetch(w);
		check(name, w, word(n));
	endtask

	task automatic rx_send(input int p, input logic [11:0] len, input logic [9:0] f);
		@(posedge ref_clk);
		#1;
		rx_evt[p] = {len, f};
		rx_evt_valid[p] = 1'b1;
		@(posedge ref_clk);
		#1;
		rx_evt_valid[p] = 1'b0;
	endtask

	task automatic tx_send(input int p, input logic [11:0] len, input logic [8:0] f,
			input logic [4:0] col);
		@(posedge ref_clk);
		#1;
		tx_evt[p] = {len, f, col};
		tx_evt_valid[p] = 1'b1;
		@(posedge ref_clk);
		#1;
		tx_evt_valid[p] = 1'b0;
	endtask

	// ======================================================================
	// scenarios
	task automatic after_reset;
		logic [39:0] w;
		logic [7:0]  b;
		check_ctr("bin64 at reset", 8'h0D, 0);
		trig(8'h6D);
		fetch(w);
		check("reserved group word", w, 40'h00_0000_0000);
		rd(8'h50, b);
		check("unmapped byte", {32'h0000_0000, b}, 40'h00_0000_0000);
	endtask

	task automatic length_bins;
		logic [11:0] ln [0:14];
		ln = '{12'h040, 12'h041, 12'h07F, 12'h080, 12'h0FF, 12'h100, 12'h1FF, 12'h200,
			12'h3FF, 12'h400, 12'h5F2, 12'h5F3, 12'h7D0, 12'h7D1, 12'h7FF};
		for (int i = 0; i < 15; i++) begin
			rx_send(0, ln[i], UCAST_RX | PRE_OK);
		end
		for (int a = 8'h0D; a <= 8'h14; a++) begin
			check_ctr("length bin", 8'(a), (a == 8'h0D) ? 1 : 2);
		end
		check_ctr("rx unicast", 8'h0C, 11);
		check_ctr("bin64 cleared", 8'h0D, 0);
	endtask

	// an event after the trigger must not disturb the word being fetched
	task automatic coherent_latch;
		logic [39:0] w;
		rx_send(0, 12'h064, PRE_OK);
		rx_send(0, 12'h064, PRE_OK);
		trig(8'h0E);
		rx_send(0, 12'h064, PRE_OK);
		fetch(w);
		check("latched word", w, word(2));
		check_ctr("count after latch", 8'h0E, 1);
	endtask

	task automatic octets;
		rx_send(1, 12'h064, PRI_RX | PRE_OK);
		rx_send(1, 12'h0C8, PRI_RX | CRC_BAD | PRE_OK);
		check_ctr("port1 octets", 8'h00, 0);
		check_ctr("port2 octets", 8'h20, 300);
	endtask

	task automatic error_classes;
		logic [11:0] ln [0:9];
		logic [9:0]  fl [0:9];
		int          ex [0:10];
		ln = '{12'h064, 12'h064, 12'h028, 12'h028, 12'h640, 12'h640, 12'h780, 12'h064,
			12'h040, 12'h050};
		fl = '{CRC_BAD, CRC_BAD | ALIGN_BAD, 10'h000, CRC_BAD, 10'h000, CRC_BAD, 10'h000,
			SYM_BAD, CTRL_RX | PAUSE_RX | MCAST_RX, BCAST_RX};
		ex = '{1, 1, 2, 2, 1, 1, 1, 1, 1, 1, 0};
		for (int i = 0; i < 10; i++) begin
			rx_send(2, ln[i], fl[i] | PRE_OK);
		end
		for (int i = 0; i < 11; i++) begin
			check_ctr("port3 error class", 8'h41 + 8'(i), ex[i]);
		end
		long_frame_mode = 1'b1;
		rx_send(2, 12'h5FA, PRE_OK);
		check_ctr("oversize long mode", 8'h43, 0);
		long_frame_mode = 1'b0;
		rx_send(2, 12'h5FA, PRE_OK);
		check_ctr("oversize std mode", 8'h43, 1);
	endtask

	task automatic tx_outcomes;
		logic [8:0] tf [0:6];
		logic [4:0] tc [0:6];
		int         ex [0:10];
		tf = '{GOOD_TX | PRI_TX | BCAST_TX, GOOD_TX | PRI_TX | PAUSE_TX, GOOD_TX | MCAST_TX |
			DEFER_TX, UCAST_TX, GOOD_TX | UCAST_TX | LATE_TX, GOOD_TX, EXCESS_TX};
		tc = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h01, 5'h03, 5'h10};
		ex = '{300, 1, 1, 1, 1, 1, 1, 20, 1, 1, 1};
		for (int i = 0; i < 7; i++) begin
			tx_send(3, (i == 1) ? 12'h0C8 : 12'h064, tf[i], tc[i]);
		end
		for (int i = 0; i < 11; i++) begin
			check_ctr("port4 tx class", 8'h95 + 8'(i), ex[i]);
		end
	endtask

	task automatic eee_bytes;
		logic [7:0] b;
		wr(`ADDR_ACCESS_CTL, 8'h20);
		wr(`ADDR_OFFSET_TRIG, 8'h31);
		wr(`ADDR_DATA_BYTE, 8'h5A);
		wr(`ADDR_ACCESS_CTL, 8'h30);
		wr(`ADDR_OFFSET_TRIG, 8'h30);
		rd(`ADDR_DATA_BYTE, b);
		check("eee high byte", {32'h0000_0000, b}, 40'h00_0000_0000);
		wr(`ADDR_OFFSET_TRIG, 8'h31);
		rd(`ADDR_DATA_BYTE, b);
		check("eee low byte", {32'h0000_0000, b}, 40'h00_0000_005A);
	endtask

	// ce low must drop events and strobes; a mid-run reset must clear what was counted
	task automatic hold_and_reset;
		logic [7:0] b;
		ce = 1'b0;
		rx_send(0, 12'h040, PRE_OK);
		wr(`ADDR_ACCESS_CTL, 8'h55);
		ce = 1'b1;
		rd(`ADDR_ACCESS_CTL, b);
		check("ctl held with ce low", {32'h0000_0000, b}, 40'h00_0000_0030);
		check_ctr("bin64 held with ce low", 8'h0D, 0);
		rx_send(0, 12'h040, PRE_OK);
		reset_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		rd(`ADDR_ACCESS_CTL, b);
		check("ctl after reset", {32'h0000_0000, b}, 40'h00_0000_0000);
		check_ctr("bin64 after reset", 8'h0D, 0);
	endtask

	// ======================================================================
	// run control
	task automatic tally_and_finish;
		if (fails == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		ce = 1'b1;
		long_frame_mode = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		rx_evt_valid = 4'h0;
		tx_evt_valid = 4'h0;
		rx_evt = '0;
		tx_evt = '0;
		fails = 0;
		samples_checked = 0;
		repeat (12) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		after_reset();
		length_bins();
		coherent_latch();
		octets();
		error_classes();
		tx_outcomes();
		eee_bytes();
		hold_and_reset();
		tally_and_finish();
	end

	// hang guard well above the roughly 700 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		tally_and_finish();
	end

endmodule // port_statistics_counters_bench
`default_nettype wire
